//--- src/dmp_prescaler.sv
// Purpose: Dual modulus prescaler dividing the clock by a selected ratio.
// Assumes: sys_clk_i stands for the high-frequency input signal.
// Notes: Build and output polarity are fixed by parameters.
//
// What this block does
// - Low build: pair high 32/33, low 64/65
// - High build: pair high 64/65, low 128/129
// - Pair static; modulus high small, low large
// - Fixed 64/65: control high 64, low 65
// - Two output polarities for either counter edge
// - Fixed build divides by 64, no selects
`timescale 1ns/1ps
module dmp_prescaler
   import dmp_pkg::*;
#(
   parameter dmp_build_t BUILD = DMP_BUILD_LOW_PAIR,
   parameter bit NEG_EDGE = 1'b0
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Ratio control pins from the synthesizer side
   input wire logic ratio_pair_select_i,
   input wire logic modulus_select_i,
   // Divided output
   output logic div_out_o
);

   // Whole divider state, registered as one word
   typedef struct packed {
      logic [DMP_CNT_W-1:0] cnt;
      logic [DMP_CNT_W-1:0] ratio;
      logic out;
   } dmp_state_t;

   dmp_state_t state_q;
   dmp_state_t state_d;

   // Pin values two clocks behind the pins
   logic [1:0] pins_sync;
   logic pair_s;
   logic mod_s;
   logic wrap;
   logic [DMP_CNT_W-1:0] base_ratio;
   logic [DMP_CNT_W-1:0] next_ratio;

   // Both control pins come from outside the clock domain; the two
   // clocks of latency mean a modulus change must stand two clocks
   // before the end of the last cycle of a period to land in the next one
   dmp_sync #(
      .W(2) // Pair select and modulus
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({ratio_pair_select_i, modulus_select_i}),
      .sync_o(pins_sync)
   );

   // Pair select is meant to be static; a change lands at a reload
   assign pair_s = pins_sync[1];
   assign mod_s = pins_sync[0];

   // Last input cycle of the current output period
   // Comparing with ratio minus one reloads without a dead cycle
   assign wrap = (state_q.cnt == state_q.ratio - DMP_DIV_EXTRA);

   // Smaller member of the active pair
   always_comb begin
      base_ratio = DMP_DIV_64;
      case (BUILD)
         DMP_BUILD_LOW_PAIR: begin
            base_ratio = pair_s ? DMP_DIV_32 : DMP_DIV_64;
         end
         DMP_BUILD_HIGH_PAIR: begin
            base_ratio = pair_s ? DMP_DIV_64 : DMP_DIV_128;
         end
         DMP_BUILD_FIXED_6465: begin
            base_ratio = DMP_DIV_64;
         end
         default: begin
            base_ratio = DMP_DIV_64;
         end
      endcase
   end

   // Modulus low adds one; the fixed build ignores the pin entirely
   // Larger member of every pair is the smaller one plus one
   always_comb begin
      if (BUILD == DMP_BUILD_FIXED_64) begin
         next_ratio = base_ratio;
      end else if (mod_s) begin
         next_ratio = base_ratio;
      end else begin
         next_ratio = base_ratio + DMP_DIV_EXTRA;
      end
   end

   // Counter, ratio latch and output phase
   always_comb begin
      state_d = state_q;
      if (wrap) begin
         // Ratio only changes between periods, never mid-cycle
         state_d.cnt = DMP_RST_CNT;
         state_d.ratio = next_ratio;
      end else begin
         state_d.cnt = state_q.cnt + 8'h01;
      end
      // Active level for the first half; odd ratios give the spare cycle to the idle level
      state_d.out = (state_d.cnt < (state_d.ratio >> 1)) ^ NEG_EDGE;
   end

   // State register; the output leaves reset low, so with NEG_EDGE clear
   // the first rising edge comes one clock into the reset-ratio period
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q.cnt <= DMP_RST_CNT;
         state_q.ratio <= DMP_RST_RATIO;
         state_q.out <= DMP_RST_OUT;
      end else begin
         state_q <= state_d;
      end
   end

   // Straight from the register, so no glitch reaches the counters
   assign div_out_o = state_q.out;

   // Checks on the divider
   // Ratio checks look one clock after the reload, through past values

   default clocking dmp_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   // Low build picks the right ratio at every reload
   a_low_pair_ratio: assert property (
      (BUILD == DMP_BUILD_LOW_PAIR) && wrap |=>
         state_q.ratio == (($past(pair_s) ? 8'h20 : 8'h40)
                           + {7'h00, !$past(mod_s)}))
      else $error("low build loaded wrong ratio");

   // High build picks the right ratio at every reload
   a_high_pair_ratio: assert property (
      (BUILD == DMP_BUILD_HIGH_PAIR) && wrap |=>
         state_q.ratio == (($past(pair_s) ? 8'h40 : 8'h80)
                           + {7'h00, !$past(mod_s)}))
      else $error("high build loaded wrong ratio");

   // Modulus low gives the odd member of the pair in every build but the fixed 64 one
   a_mod_low_odd: assert property (
      (BUILD != DMP_BUILD_FIXED_64) && wrap && !mod_s |=>
         state_q.ratio[0] == 1'b1)
      else $error("modulus low did not select larger ratio");

   // Fixed 64/65 build follows the control pin only
   a_fixed_6465_ratio: assert property (
      (BUILD == DMP_BUILD_FIXED_6465) && wrap |=>
         state_q.ratio == ($past(mod_s) ? 8'h40 : 8'h41))
      else $error("fixed 64/65 build loaded wrong ratio");

   // Output period edge sits at counter zero with the built polarity
   a_period_edge: assert property (
      wrap |=> (div_out_o == !NEG_EDGE) ##1
         (div_out_o == !NEG_EDGE || state_q.ratio < 8'h04))
      else $error("output edge misplaced for polarity");

   // Fixed build stays at 64 once the first period ends
   a_fixed_64_hold: assert property (
      (BUILD == DMP_BUILD_FIXED_64) && wrap |=>
         state_q.ratio == 8'h40 && state_q.cnt == 8'h00)
      else $error("fixed build left divide by 64");

   // Ratio holds for a whole output period
   a_ratio_per_period: assert property (
      !wrap |=> $stable(state_q.ratio))
      else $error("ratio changed inside an output period");

   // Counter never runs past the loaded ratio
   a_cnt_in_range: assert property (
      state_q.cnt < state_q.ratio)
      else $error("counter beyond ratio");

   // Counter restarts at zero right after the last cycle
   a_wrap_restart: assert property (
      wrap |=> state_q.cnt == 8'h00)
      else $error("counter did not restart after a period");

   // Inside a period the counter moves by exactly one per clock
   a_count_step: assert property (
      !wrap |=> state_q.cnt == $past(state_q.cnt) + 8'h01)
      else $error("counter skipped or stalled inside a period");

   // Last cycle of a period shows the idle level of the polarity
   a_last_cycle_idle: assert property (
      wrap |-> div_out_o == NEG_EDGE)
      else $error("output not idle in the last cycle of a period");

   // Output turns idle halfway; the spare cycle of odd ratios is idle
   a_half_period_edge: assert property (
      state_q.cnt == (state_q.ratio >> 1) |->
         div_out_o == NEG_EDGE && $past(div_out_o) == !NEG_EDGE)
      else $error("output did not turn idle at mid period");

   // Only members of the supported pairs are ever loaded
   a_ratio_legal: assert property (
      state_q.ratio inside {8'h20, 8'h21, 8'h40, 8'h41, 8'h80, 8'h81})
      else $error("ratio outside every supported pair");

   // Modulus high always gives the even, smaller member
   a_mod_high_even: assert property (
      wrap && mod_s |=> state_q.ratio[0] == 1'b0)
      else $error("modulus high did not select smaller ratio");

   // Fixed build never holds anything but 64
   a_fixed_64_const: assert property (
      (BUILD == DMP_BUILD_FIXED_64) |-> state_q.ratio == 8'h40)
      else $error("fixed build holds a ratio other than 64");

   // Fixed 64/65 build never loads a ratio of the other pairs
   a_fixed_6465_pair: assert property (
      (BUILD == DMP_BUILD_FIXED_6465) |-> state_q.ratio[7:1] == 7'h20)
      else $error("fixed 64/65 build left its pair");

endmodule // dmp_prescaler

//--- src/dmp_pkg.sv
// Purpose: Shared constants and types for the dual modulus prescaler.
// Assumes: One clock; the divided input signal is the system clock.
// Notes: Ratio values are small enough for an 8-bit counter.
package dmp_pkg;

   // Build variants of the prescaler
   typedef enum logic [1:0] {
      DMP_BUILD_LOW_PAIR,
      DMP_BUILD_HIGH_PAIR,
      DMP_BUILD_FIXED_6465,
      DMP_BUILD_FIXED_64
   } dmp_build_t;

   // Counter and ratio width
   localparam int DMP_CNT_W = 8;

   // Division ratios
   localparam logic [7:0] DMP_DIV_32 = 8'h20;
   localparam logic [7:0] DMP_DIV_64 = 8'h40;
   localparam logic [7:0] DMP_DIV_128 = 8'h80;
   localparam logic [7:0] DMP_DIV_EXTRA = 8'h01;

   // Reset values
   localparam logic [7:0] DMP_RST_RATIO = 8'h40;
   localparam logic [7:0] DMP_RST_CNT = 8'h00;
   localparam logic DMP_RST_OUT = 1'b0;

   // Synchroniser depth for pin inputs
   localparam int DMP_SYNC_STAGES = 2;

   // Clock period and the modulus response window of the far side
   localparam int DMP_CLK_PERIOD_PS = 4000;
   localparam int DMP_MODULUS_RESPONSE_WINDOW_NS = 42;
   // Longest time, so it rounds down
   localparam int DMP_MODULUS_RESPONSE_WINDOW_CYC =
      (DMP_MODULUS_RESPONSE_WINDOW_NS * 1000) / DMP_CLK_PERIOD_PS;

endpackage

//--- src/dmp_sync.sv
// Purpose: Two flip-flop synchroniser for static and slow pin inputs.
// Assumes: Inputs are asynchronous to sys_clk_i.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/1ps
module dmp_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Pin side
   input wire logic [W-1:0] async_i,
   // Clock side
   output logic [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } dmp_sync_state_t;

   dmp_sync_state_t state_q;
   dmp_sync_state_t state_d;

   // First stage feeds only the second stage
   always_comb begin
      state_d = state_q;
      state_d.meta = async_i;
      state_d.stable = state_q.meta;
   end

   // State register
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign sync_o = state_q.stable;

endmodule // dmp_sync

//--- dv/dmp_synth_model.sv
// Purpose: Synthesizer counter model facing one prescaler output.
// Assumes: A period starts when the active output level arrives.
// Notes: Moves modulus one cycle after a period start, inside the window.
`timescale 1ns/1ps
module dmp_synth_model #(
   parameter bit NEG = 1'b0
) (
   // Clock
   input wire logic clk_i,
   // Prescaler side
   input wire logic div_i,
   input wire logic want_i,
   output logic mod_o,
   // Last measured period and active time, in clocks
   output logic [7:0] per_o,
   output logic [7:0] act_o
);
   logic prev;
   logic act;
   logic [7:0] cnt;
   logic [7:0] ac;
   assign act = div_i ^ NEG;
   // Known start so the prescaler never sees an unknown pin
   initial begin
      prev = 1'b0;
      cnt = 8'h00;
      ac = 8'h00;
      mod_o = 1'b1;
   end
   // Counts on the edge the synthesizer would trigger on
   always @(posedge clk_i) begin
      prev <= act;
      if (act && !prev) begin
         per_o <= cnt;
         act_o <= ac;
         cnt <= 8'h01;
         ac <= 8'h01;
         mod_o <= want_i;
      end else begin
         cnt <= cnt + 8'h01;
         ac <= ac + {7'h00, act};
      end
   end
endmodule // dmp_synth_model

//--- dv/test_dual_modulus_prescaler.sv
// Purpose: Self-checking bench for all four prescaler builds at once.
// Assumes: Pair and want are driven on the falling clock edge, modulus pins on the rising edge.
// Notes: Build 1 runs with the inverted output polarity.
`timescale 1ns/1ps
module test_dual_modulus_prescaler
   import dmp_pkg::*;
;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic pair = 1'b1;
   logic want = 1'b1;
   wire [3:0] mod;
   wire [3:0] div;
   wire [7:0] per [4];
   wire [7:0] act [4];
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   // Rows: pair, modulus, then period of builds 0 to 3
   logic [33:0] rows [4] = '{{2'h3, 8'h20, 8'h40, 8'h40, 8'h40},
      {2'h2, 8'h21, 8'h41, 8'h41, 8'h40},
      {2'h1, 8'h40, 8'h80, 8'h40, 8'h40},
      {2'h0, 8'h41, 8'h81, 8'h41, 8'h40}};
   // One prescaler and one synthesizer model per build
   for (genvar g = 0; g < 4; g++) begin : gb
      dmp_prescaler #(.BUILD(dmp_build_t'(g)), .NEG_EDGE(g == 1)) dut (
         .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
         .ratio_pair_select_i(pair), .modulus_select_i(mod[g]),
         .div_out_o(div[g]));
      dmp_synth_model #(.NEG(g == 1)) far (
         .clk_i(sys_clk_i), .div_i(div[g]), .want_i(want),
         .mod_o(mod[g]), .per_o(per[g]), .act_o(act[g]));
   end
   always #2 sys_clk_i = ~sys_clk_i;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Hang guard, well above the 1716 cycles the run needs
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      repeat (3) @(negedge sys_clk_i);
      sys_rst_i = 1'b0;
      // Every pin combination; each settles over two periods
      for (int i = 0; i < 4; i++) begin
         {pair, want} = rows[i][33:32];
         repeat (400) @(negedge sys_clk_i);
         for (int b = 0; b < 4; b++) begin
            chk(per[b], rows[i][31-8*b -: 8]);
            chk(act[b], rows[i][31-8*b -: 8] >> 1);
         end
      end
      // Mid-run reset: low output, then a reset-ratio period first
      {pair, want} = 2'h3;
      sys_rst_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      for (int b = 0; b < 4; b++) begin
         chk({7'h00, div[b]}, 8'h00);
      end
      sys_rst_i = 1'b0;
      repeat (70) @(negedge sys_clk_i);
      // Output leaves reset low, so the first rise is one clock late
      chk(per[0], DMP_RST_RATIO - 8'h01);
      repeat (40) @(negedge sys_clk_i);
      chk(per[0], 8'h20);
      summarize();
   end
endmodule // test_dual_modulus_prescaler
